// file: core/dhrpc_ctrl.sv
// Debug halt, resume and power-state control for one core.
// Assumes power unit and multi-core debug pins are asynchronous,
// core-side debug and idle signals come from logic on pclk.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "dhrpc_defs.svh"
module dhrpc_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire dhrpc_pkg::dhrpc_word_t pwdata,
  output dhrpc_pkg::dhrpc_word_t prdata,
  output logic pready,
  output logic pslverr,
  // Power unit, asynchronous
  input wire logic pmu_halt_req,
  input wire logic pmu_run_req,
  output logic pmu_halt_ack,
  output logic pmu_run_ack,
  output logic cpu_halt_status,
  // Multi-core debug controller, asynchronous
  input wire logic mcdc_halt_req,
  input wire logic mcdc_run_req,
  input wire logic mcdc_boot_debug,
  output logic mcdc_halt_ack,
  output logic mcdc_run_ack,
  output logic debug_mode_status,
  output logic debug_brkpt_status,
  // Core debug module, same clock
  input wire logic dbg_halt_req,
  input wire logic dbg_resume_req,
  input wire logic dbg_step,
  input wire logic dbg_brkpt,
  input wire logic dbg_trigger,
  // Core pipeline, same clock
  input wire logic core_idle,
  input wire logic rd_buf_empty,
  input wire logic wr_buf_empty,
  input wire logic ic_miss_idle,
  output logic core_stall,
  output logic enh_clk_gate
);
  import dhrpc_pkg::*;

  logic [4:0] sync_w;
  logic pmu_halt_s;
  logic pmu_run_s;
  logic mcdc_halt_s;
  logic mcdc_run_s;
  logic boot_dbg_s;
  dhrpc_state_e state_r;
  dhrpc_state_e state_nxt;
  logic debug_halted_state_r;
  logic ctrl_halt_state_bit_r;
  logic [1:0] boot_cnt_r;
  logic fw_halt_r;
  logic mcdc_halt_d_r;
  logic dbg_cause;
  logic dbg_entry;
  logic quiesced;
  logic resume_ok;
  logic leave_dbg;
  logic step_ok;
  logic apb_acc;
  logic apb_wr;
  logic apb_hit;
  dhrpc_word_t stat_w;

  // Asynchronous pins pass two flops before use
  dhrpc_sync #(
    .WIDTH(5)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({mcdc_boot_debug, mcdc_run_req, mcdc_halt_req, pmu_run_req, pmu_halt_req}),
    .sync_out(sync_w)
  );
  assign pmu_halt_s = sync_w[0];
  assign pmu_run_s = sync_w[1];
  assign mcdc_halt_s = sync_w[2];
  assign mcdc_run_s = sync_w[3];
  assign boot_dbg_s = sync_w[4];

  // Debug entry causes; controller halt is sampled as a new request
  assign dbg_cause = dbg_halt_req | dbg_brkpt | dbg_trigger | dbg_step;
  assign dbg_entry = dbg_cause | (mcdc_halt_s & ~mcdc_halt_d_r);
  // Quiet needs core idle, read and write buffers empty and no icache miss outstanding
  assign quiesced = core_idle & rd_buf_empty & wr_buf_empty & ic_miss_idle;
  assign resume_ok = dbg_resume_req & ~dbg_step;
  // Exit table: each set bit needs its own release, unset bits ignore theirs
  assign leave_dbg = (debug_halted_state_r | ctrl_halt_state_bit_r)
    & (~debug_halted_state_r | resume_ok)
    & (~ctrl_halt_state_bit_r | mcdc_run_s);
  // Step refused while the controller still holds the core
  assign step_ok = dbg_resume_req & dbg_step & debug_halted_state_r
    & ~ctrl_halt_state_bit_r;

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_BOOT:
        if (boot_cnt_r == `DHRPC_BOOT_WAIT)
          state_nxt = boot_dbg_s ? ST_DBG : ST_RUN;
      ST_RUN:
        if (dbg_entry)
          state_nxt = ST_DBG;
        else if (pmu_halt_s || fw_halt_r)
          state_nxt = ST_QUIESCE;
      ST_QUIESCE:
        if (dbg_entry)
          state_nxt = ST_DBG;
        else if (quiesced)
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        if (dbg_entry)
          state_nxt = ST_DBG;
        else if (pmu_run_s && !pmu_halt_s)
          state_nxt = ST_RUN;
      ST_DBG:
        if (leave_dbg)
          state_nxt = pmu_halt_s ? ST_QUIESCE : ST_RUN;
        else if (step_ok)
          state_nxt = ST_STEP;
      ST_STEP:
        state_nxt = ST_DBG;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= ST_BOOT;
    else
      state_r <= state_nxt;
  end

  // Wait for the strap to pass its synchroniser before trusting it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boot_cnt_r <= 2'h0;
    else if (state_r == ST_BOOT)
      boot_cnt_r <= boot_cnt_r + 2'h1;
  end

  // Edge history of controller halt, so a held level does not re-enter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mcdc_halt_d_r <= 1'b0;
    else
      mcdc_halt_d_r <= mcdc_halt_s;
  end

  // Halt-source bookkeeping bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      debug_halted_state_r <= 1'b0;
      ctrl_halt_state_bit_r <= 1'b0;
    end
    else if (state_r == ST_DBG && leave_dbg)
    begin
      debug_halted_state_r <= 1'b0;
      ctrl_halt_state_bit_r <= 1'b0;
    end
    else if (state_r == ST_BOOT)
      ctrl_halt_state_bit_r <= (boot_cnt_r == `DHRPC_BOOT_WAIT) & boot_dbg_s;
    else
    begin
      if (dbg_cause)
        debug_halted_state_r <= 1'b1;
      if (mcdc_halt_s && !mcdc_halt_d_r)
        ctrl_halt_state_bit_r <= 1'b1;
    end
  end

  // Breakpoint- or trigger-caused entry flag for cross-triggering
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      debug_brkpt_status <= 1'b0;
    else if (state_nxt != ST_DBG && state_nxt != ST_STEP)
      debug_brkpt_status <= 1'b0;
    else if (state_r != ST_DBG && (dbg_brkpt || dbg_trigger))
      debug_brkpt_status <= 1'b1;
  end

  // Status outputs follow the next state so they line up with it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      debug_mode_status <= 1'b0;
      cpu_halt_status <= 1'b0;
      core_stall <= 1'b1;
      enh_clk_gate <= 1'b0;
    end
    else
    begin
      // Step runs one instruction with debug mode shown low
      debug_mode_status <= (state_nxt == ST_DBG);
      cpu_halt_status <= (state_nxt == ST_SLEEP);
      core_stall <= (state_nxt != ST_RUN) && (state_nxt != ST_STEP);
      // Fine gating lives in the datapath; enhanced only in sleep
      enh_clk_gate <= (state_nxt == ST_SLEEP);
    end
  end

  // Handshake acks as levels: three follow request and next state, controller run ack holds until its request drops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pmu_halt_ack <= 1'b0;
      pmu_run_ack <= 1'b0;
      mcdc_halt_ack <= 1'b0;
      mcdc_run_ack <= 1'b0;
    end
    else
    begin
      pmu_halt_ack <= pmu_halt_s & (state_nxt == ST_SLEEP);
      pmu_run_ack <= pmu_run_s & (state_nxt == ST_RUN);
      mcdc_halt_ack <= mcdc_halt_s & (state_nxt == ST_DBG);
      if (!mcdc_run_s)
        mcdc_run_ack <= 1'b0;
      else if (state_r == ST_DBG && leave_dbg && ctrl_halt_state_bit_r)
        mcdc_run_ack <= 1'b1;
    end
  end

  // APB decode; one wait state keeps every output registered
  assign apb_acc = psel & penable & ~pready;
  assign apb_wr = psel & penable & pready & pwrite;
  assign apb_hit = (paddr == `DHRPC_OFS_CTRL) || (paddr == `DHRPC_OFS_STAT);

  always_comb
  begin
    stat_w = '0;
    stat_w[`DHRPC_STAT_DBG] = (state_r == ST_DBG);
    stat_w[`DHRPC_STAT_SLEEP] = (state_r == ST_SLEEP);
    stat_w[`DHRPC_STAT_DBGBIT] = debug_halted_state_r;
    stat_w[`DHRPC_STAT_CTLBIT] = ctrl_halt_state_bit_r;
    stat_w[`DHRPC_STAT_BRK] = debug_brkpt_status;
    stat_w[`DHRPC_STAT_QUIESCE] = (state_r == ST_QUIESCE);
    stat_w[`DHRPC_STAT_PWR_LO+1:`DHRPC_STAT_PWR_LO] =
      (state_r == ST_SLEEP) ? `DHRPC_PWR_SLEEP : `DHRPC_PWR_ACTIVE;
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apb_acc;
      pslverr <= apb_acc & ~apb_hit;
      if (apb_acc && !pwrite && paddr == `DHRPC_OFS_STAT)
        prdata <= stat_w;
      else if (apb_acc && !pwrite && paddr == `DHRPC_OFS_CTRL)
        prdata <= {31'h0000_0000, fw_halt_r};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Firmware halt request; cleared once asleep, refused in debug mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fw_halt_r <= 1'b0;
    else if (apb_wr && paddr == `DHRPC_OFS_CTRL && pwdata[`DHRPC_CTRL_FWHALT]
             && state_r == ST_RUN)
      fw_halt_r <= 1'b1;
    else if (state_r == ST_SLEEP || state_r == ST_DBG)
      fw_halt_r <= 1'b0;
  end

  // Checks
  only_db_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DBG && debug_halted_state_r && !ctrl_halt_state_bit_r && !resume_ok
    |=> state_r == ST_DBG || state_r == ST_STEP)
    else $error("left debug without core resume");
  resume_ign_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DBG && !debug_halted_state_r && ctrl_halt_state_bit_r && !mcdc_run_s
    |=> state_r == ST_DBG)
    else $error("core resume honoured without its halt bit");
  run_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DBG && !debug_halted_state_r && ctrl_halt_state_bit_r && mcdc_run_s
    |=> state_r != ST_DBG && !debug_mode_status)
    else $error("controller run did not release core");
  both_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DBG && debug_halted_state_r && ctrl_halt_state_bit_r
    |=> (state_r == ST_DBG) == !($past(resume_ok) && $past(mcdc_run_s)))
    else $error("both-bit release wrong");
  bits_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(debug_mode_status) && state_r != ST_STEP
    |-> !debug_halted_state_r && !ctrl_halt_state_bit_r)
    else $error("halt bits survive debug exit");
  step_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DBG && ctrl_halt_state_bit_r |=> state_r != ST_STEP)
    else $error("single step while controller holds core");
  pmu_ign_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DBG && pmu_halt_s && !leave_dbg |=> state_r != ST_QUIESCE)
    else $error("power halt taken in debug mode");
  pmu_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DBG && leave_dbg && pmu_halt_s |=> state_r == ST_QUIESCE)
    else $error("pending power halt lost at debug exit");
  sleep_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_QUIESCE && quiesced && !dbg_entry
    |=> cpu_halt_status && enh_clk_gate && core_stall)
    else $error("sleep entry not indicated");
  boot_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_BOOT && boot_cnt_r == `DHRPC_BOOT_WAIT && boot_dbg_s
    |=> debug_mode_status && ctrl_halt_state_bit_r)
    else $error("boot into debug not honoured");
  cv_sleep_wake: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_SLEEP ##1 state_r == ST_RUN);
  cv_both_rel: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DBG && debug_halted_state_r && ctrl_halt_state_bit_r && leave_dbg);
  cv_step: cover property (@(posedge pclk) disable iff (!presetn) state_r == ST_STEP);
  cv_pend: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_DBG && leave_dbg && pmu_halt_s);
endmodule

// file: core/dhrpc_defs.svh
// Constants for the debug halt / resume / power control block.
// Assumes a 32-bit APB bus with word-aligned registers.
`ifndef DHRPC_DEFS_SVH
`define DHRPC_DEFS_SVH
`define DHRPC_OFS_CTRL 12'h000
`define DHRPC_OFS_STAT 12'h004
`define DHRPC_CTRL_FWHALT 0
`define DHRPC_STAT_DBG 0
`define DHRPC_STAT_SLEEP 1
`define DHRPC_STAT_DBGBIT 2
`define DHRPC_STAT_CTLBIT 3
`define DHRPC_STAT_BRK 4
`define DHRPC_STAT_QUIESCE 5
`define DHRPC_STAT_PWR_LO 8
`define DHRPC_PWR_ACTIVE 2'h0
`define DHRPC_PWR_SLEEP 2'h1
`define DHRPC_BOOT_WAIT 2'h3
`endif

// file: core/dhrpc_pkg.sv
// Types for the debug halt / resume / power control block.
// Assumes nothing beyond the constants header.
package dhrpc_pkg;
  typedef enum logic [2:0]
  {
    ST_BOOT,
    ST_RUN,
    ST_QUIESCE,
    ST_SLEEP,
    ST_DBG,
    ST_STEP
  } dhrpc_state_e;
  typedef logic [31:0] dhrpc_word_t;
endpackage

// file: core/dhrpc_sync.sv
// Two-flop synchroniser bank for asynchronous control pins.
// Assumes inputs are quasi-static levels held for several clocks.
`timescale 1ns/10ps
module dhrpc_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  initial
  begin
    if (WIDTH < 1)
      $error("dhrpc_sync: WIDTH must be at least 1");
  end

  // Each bit gets its own pair; first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_r[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end
        else
        begin
          meta_r[gi] <= async_in[gi];
          sync_out[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate
endmodule

// file: tb/dhrpc_ctrl_test.sv
// Self-checking bench for the debug halt, resume and power control block.
// Assumes the far-side model drives the power unit and controller pins.
`timescale 1ns/10ps
`include "dhrpc_defs.svh"
module dhrpc_ctrl_test;
  import dhrpc_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  dhrpc_word_t pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pmu_halt_req, pmu_run_req, pmu_halt_ack, pmu_run_ack;
  logic cpu_halt_status, mcdc_halt_req, mcdc_run_req, mcdc_boot_debug, mcdc_halt_ack;
  logic mcdc_run_ack, debug_mode_status, debug_brkpt_status, core_stall, enh_clk_gate;
  logic dbg_halt_req = 1'h0, dbg_resume_req = 1'h0, dbg_step = 1'h0, dbg_brkpt = 1'h0;
  logic dbg_trigger = 1'h0, ph_w = 1'h0, pr_w = 1'h0, mh_w = 1'h0, mr_w = 1'h0, boot_w = 1'h0;
  logic [3:0] quiet = 4'hF;
  logic [1:0] lag = 2'h0;
  int n_fail = 0, checks_done = 0, cycles = 0, seed = 90, m_db = 0, m_ctl = 0, lv;

  dhrpc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pmu_halt_req(pmu_halt_req), .pmu_run_req(pmu_run_req),
    .pmu_halt_ack(pmu_halt_ack), .pmu_run_ack(pmu_run_ack), .cpu_halt_status(cpu_halt_status),
    .mcdc_halt_req(mcdc_halt_req), .mcdc_run_req(mcdc_run_req),
    .mcdc_boot_debug(mcdc_boot_debug), .mcdc_halt_ack(mcdc_halt_ack),
    .mcdc_run_ack(mcdc_run_ack), .debug_mode_status(debug_mode_status),
    .debug_brkpt_status(debug_brkpt_status), .dbg_halt_req(dbg_halt_req),
    .dbg_resume_req(dbg_resume_req), .dbg_step(dbg_step), .dbg_brkpt(dbg_brkpt),
    .dbg_trigger(dbg_trigger), .core_idle(quiet[3]), .rd_buf_empty(quiet[2]),
    .wr_buf_empty(quiet[1]), .ic_miss_idle(quiet[0]), .core_stall(core_stall),
    .enh_clk_gate(enh_clk_gate));
  dhrpc_far_model far (.pclk(pclk), .ph_w(ph_w), .pr_w(pr_w), .mh_w(mh_w), .mr_w(mr_w),
    .boot_w(boot_w), .lag(lag), .pmu_halt_req(pmu_halt_req), .pmu_run_req(pmu_run_req),
    .mcdc_halt_req(mcdc_halt_req), .mcdc_run_req(mcdc_run_req),
    .mcdc_boot_debug(mcdc_boot_debug));

  // 10 MHz clock and a hang guard
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Sample at the falling edge, after the rising edge updates land
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // One APB transfer; waits for pready with a bound
  task automatic apb(input logic wr, input logic [11:0] a, input dhrpc_word_t d);
    int g;
    g = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && g < 20)
    begin
      g++;
      @(posedge pclk);
    end
    if (g == 20)
    begin
      n_fail++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Expected status word from the bench model
  function automatic dhrpc_word_t st(input int dbg, input int slp);
    st = 32'(dbg) << `DHRPC_STAT_DBG | 32'(m_db) << `DHRPC_STAT_DBGBIT;
    st = st | 32'(m_ctl) << `DHRPC_STAT_CTLBIT | 32'(slp) << `DHRPC_STAT_SLEEP;
    st = st | 32'(slp) << `DHRPC_STAT_PWR_LO;
  endfunction

  // One-cycle core debug event: 0 halt, 1 breakpoint, 2 trigger, 3 step
  task automatic pulse(input int k);
    @(posedge pclk) {dbg_step, dbg_trigger, dbg_brkpt, dbg_halt_req} <= 4'(1 << k);
    @(posedge pclk) {dbg_step, dbg_trigger, dbg_brkpt, dbg_halt_req} <= 4'h0;
  endtask

  task automatic wake();
    @(posedge pclk) pr_w <= 1'h1;
    wt(16);
    chk({cpu_halt_status, pmu_run_ack, core_stall, enh_clk_gate}, 4'h4);
    @(posedge pclk) pr_w <= 1'h0;
  endtask

  // Resume and run together always end debug; both bits must clear
  task automatic release_all();
    @(posedge pclk)
    begin
      dbg_resume_req <= 1'h1;
      mr_w <= 1'h1;
    end
    wt(10);
    @(posedge pclk)
    begin
      dbg_resume_req <= 1'h0;
      mr_w <= 1'h0;
    end
    m_db = 0;
    m_ctl = 0;
    apb(1'h0, `DHRPC_OFS_STAT, 32'h0);
    chk({debug_mode_status, rd}, {1'h0, st(0, 0)});
  endtask

  // Main sequence
  initial
  begin
    wt(3);
    chk({core_stall, debug_mode_status, cpu_halt_status, enh_clk_gate, pready}, 5'h10);
    @(posedge pclk) presetn <= 1'h1;
    wt(8);
    chk({core_stall, debug_mode_status}, 2'h0);
    apb(1'h0, `DHRPC_OFS_STAT, 32'h0);
    chk({err, rd}, {1'h0, st(0, 0)});
    apb(1'h1, 12'h010, 32'($random(seed)));
    chk(err, 1'h1);
    apb(1'h0, 12'h00C, 32'h0);
    chk({err, rd}, 33'h100000000);
    // Firmware halt waits for every quiet input in turn
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk) quiet <= 4'hF ^ 4'(1 << i);
      if (i == 0)
        apb(1'h1, `DHRPC_OFS_CTRL, 32'h1);
      wt(5);
      chk({core_stall, cpu_halt_status}, 2'h2);
    end
    @(posedge pclk) quiet <= 4'hF;
    wt(4);
    chk({cpu_halt_status, enh_clk_gate, debug_mode_status}, 3'h6);
    apb(1'h0, `DHRPC_OFS_STAT, 32'h0);
    chk(rd, st(0, 1));
    wake();
    @(posedge pclk) ph_w <= 1'h1;
    wt(12);
    chk({cpu_halt_status, pmu_halt_ack, enh_clk_gate}, 3'h7);
    @(posedge pclk) ph_w <= 1'h0;
    wake();
    // Halt-source table: c picks the bits, r the resume and run levels
    for (int c = 1; c < 4; c++)
      for (int r = 0; r < 4; r++)
      begin
        lag <= 2'($random(seed));
        if (c[0])
          pulse(0);
        if (c[1])
        begin
          @(posedge pclk) mh_w <= 1'h1;
          wt(10);
          chk({debug_mode_status, mcdc_halt_ack}, 2'h3);
          @(posedge pclk) mh_w <= 1'h0;
        end
        m_db = c[0];
        m_ctl = c[1];
        apb(1'h0, `DHRPC_OFS_STAT, 32'h0);
        chk(rd, st(1, 0));
        @(posedge pclk)
        begin
          dbg_resume_req <= r[0];
          mr_w <= r[1];
        end
        lv = (m_db == 0 || r[0]) && (m_ctl == 0 || r[1]);
        wt(1);
        if (c == 1)
          chk(debug_mode_status, !lv);
        wt(10);
        chk(debug_mode_status, !lv);
        chk(mcdc_run_ack, lv && m_ctl);
        release_all();
      end
    // Step with only the debug bit runs one cycle, then halts again
    pulse(0);
    @(posedge pclk) {dbg_resume_req, dbg_step} <= 2'h3;
    @(posedge pclk) {dbg_resume_req, dbg_step} <= 2'h0;
    @(negedge pclk);
    chk({debug_mode_status, core_stall}, 2'h0);
    wt(2);
    chk(debug_mode_status, 1'h1);
    release_all();
    // Step ignored under controller halt; resume with step stays
    @(posedge pclk) mh_w <= 1'h1;
    wt(10);
    @(posedge pclk) mh_w <= 1'h0;
    pulse(3);
    for (int i = 0; i < 3; i++)
    begin
      @(negedge pclk);
      chk(debug_mode_status, 1'h1);
    end
    pulse(0);
    @(posedge pclk) {dbg_resume_req, dbg_step} <= 2'h3;
    @(posedge pclk) {dbg_resume_req, dbg_step} <= 2'h0;
    wt(4);
    chk(debug_mode_status, 1'h1);
    release_all();
    // Breakpoint and trigger entry; power halt held off during debug
    for (int k = 1; k < 3; k++)
    begin
      pulse(k);
      @(negedge pclk);
      chk({debug_mode_status, debug_brkpt_status}, 2'h3);
      apb(1'h1, `DHRPC_OFS_CTRL, 32'h1);
      @(posedge pclk) ph_w <= k[1];
      wt(12);
      chk(cpu_halt_status, 1'h0);
      @(posedge pclk) dbg_resume_req <= 1'h1;
      @(posedge pclk) dbg_resume_req <= 1'h0;
      wt(10);
      chk({debug_brkpt_status, cpu_halt_status}, 2'(k - 1));
      if (k == 2)
      begin
        @(posedge pclk) ph_w <= 1'h0;
        wake();
      end
    end
    // Second reset with debug chosen at boot
    @(posedge pclk)
    begin
      boot_w <= 1'h1;
      presetn <= 1'h0;
    end
    wt(3);
    @(posedge pclk) presetn <= 1'h1;
    wt(8);
    m_ctl = 1;
    apb(1'h0, `DHRPC_OFS_STAT, 32'h0);
    chk({debug_mode_status, rd}, {1'h1, st(1, 0)});
    release_all();
    test_done();
  end
endmodule

// file: tb/dhrpc_far_model.sv
// Far-side model: power unit and multi-core debug controller pins.
// Assumes the bench sets wanted levels; request pins follow after lag cycles.
`timescale 1ns/10ps
module dhrpc_far_model (
  // Clock
  input wire logic pclk,
  // Wanted levels from the bench
  input wire logic ph_w,
  input wire logic pr_w,
  input wire logic mh_w,
  input wire logic mr_w,
  input wire logic boot_w,
  input wire logic [1:0] lag,
  // Pins towards the core
  output logic pmu_halt_req,
  output logic pmu_run_req,
  output logic mcdc_halt_req,
  output logic mcdc_run_req,
  output logic mcdc_boot_debug
);
  int wait_n = 0;
  logic [3:0] tgt;
  logic [3:0] pins_r = 4'h0;
  // Boot choice is a plain strap level
  assign mcdc_boot_debug = boot_w;
  // Run only rises once the halt pin is already low
  assign tgt = {ph_w, pr_w & ~ph_w & ~pmu_halt_req, mh_w, mr_w & ~mh_w & ~mcdc_halt_req};
  // One process owns the pin levels
  assign {pmu_halt_req, pmu_run_req, mcdc_halt_req, mcdc_run_req} = pins_r;
  // Slow answers: pins move lag cycles late, unrelated to core timing
  always @(posedge pclk)
  begin
    if (pins_r != tgt)
    begin
      if (wait_n >= lag)
      begin
        pins_r <= tgt;
        wait_n <= 0;
      end
      else
        wait_n <= wait_n + 1;
    end
  end
endmodule
